/* File: rtl/lmcd_pkg.sv */
`default_nettype none
package lmcd_pkg;
  // Frame kinds as delivered by the frame layer.
  localparam logic [3:0] PTR_GP2        = 4'h0;
  localparam logic [3:0] PTR_GP4        = 4'h1;
  localparam logic [5:0] ID_DIAG        = 6'h3C;
  localparam logic [7:0] APP_SEL        = 8'h80;
  localparam logic [6:0] CMD_RUN        = 7'h17;
  localparam logic [6:0] CMD_ZERO       = 7'h06;
  localparam logic [6:0] CMD_DUAL       = 7'h08;
  localparam logic [6:0] CMD_MOTOR      = 7'h09;
  localparam logic [6:0] CMD_FUSE       = 7'h10;
  localparam logic [6:0] CMD_STALL      = 7'h16;
  localparam logic [6:0] CMD_ABS        = 7'h0B;
  localparam logic [7:0] FILL_BYTE      = 8'hFF;
  localparam logic [4:0] FUSE_ADDR_MARK = 5'h1F;
  // Avalon register map, byte addresses.
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_PARAM0     = 8'h08;
  localparam logic [7:0] REG_PARAM1     = 8'h0C;
  localparam logic [7:0] REG_TARGET     = 8'h10;
  localparam logic [7:0] REG_FUSE       = 8'h14;
  localparam logic [7:0] REG_DROPS      = 8'h18;
  localparam logic [6:0] NODE_ADDR_RST  = 7'h00;
  // Lost-link timeout, in microseconds, and its cycle count at 100 MHz.
  localparam int         CLK_MHZ        = 100;
  localparam int         LOST_US        = 100;
  localparam int         LOST_CYCLES    = LOST_US * CLK_MHZ;
  typedef enum logic [2:0] {
    LMCD_IDLE = 3'b000,
    LMCD_RUN  = 3'b001,
    LMCD_ABS  = 3'b010,
    LMCD_DUAL1 = 3'b011,
    LMCD_DUAL2 = 3'b100,
    LMCD_LOST = 3'b101
  } lmcd_state_t;
endpackage
`default_nettype wire

/* File: rtl/lmcd_addr_match.sv */
`default_nettype none
// Node addressing: a clear broadcast bit means every node obeys.
module lmcd_addr_match (
  input  wire logic [7:0] i_addr_byte,
  input  wire logic [6:0] i_node_addr,
  output logic            o_hit
);
  assign o_hit = !i_addr_byte[7] || (i_addr_byte[6:0] == i_node_addr); // [RULE4]
endmodule
`default_nettype wire

/* File: rtl/lmcd_top.sv */
// Added by the designer: the address map and the Avalon-MM register port.
`default_nettype none
// Behaviour
// (RULE1) Run command from pointer 0000, code 0x17.
// (RULE2) Continuous run ignores stored direction bit.
// (RULE3) Link silence during run starts autonomous motion.
// (RULE4) Clear broadcast bit: all nodes obey.
// (RULE5) Decode dual positioning frame fields.
// (RULE6) First move absolute, second relative at minimum.
// (RULE7) Dual sequence end sets reference-done.
// (RULE8) Running dual sequence blocks other positioning.
// (RULE9) Stall command writes parameter RAM.
// (RULE10) Unpack stall parameter fields as laid out.
// (RULE11) Motor command stores motor parameters.
// (RULE12) Unpack motor parameter fields, fixed ones.
// (RULE13) Motor command updates running motion immediately.
// (RULE14) Master changes only velocities mid-motion.
// (RULE15) Fuse command programs addressed fuse byte.
// (RULE16) Absolute move, dropped when arbitration forbids.
// (RULE17) Zero-position command sets reference-done.
// (RULE18) Bad checksum or parity frames discarded.
// (RULE19) Unknown application byte or command ignored.
module lmcd_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESET,
  input  wire logic        i_frame_valid,
  input  wire logic        i_frame_ok,
  input  wire logic [5:0]  i_frame_id,
  input  wire logic [3:0]  i_frame_ptr,
  input  wire logic [63:0] i_frame_data,
  input  wire logic        i_move_done,
  input  wire logic        i_abs_forbid,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_move_start,
  output logic [15:0]      o_move_target,
  output logic             o_move_relative,
  output logic [3:0]       o_move_vmax,
  output logic [3:0]       o_move_vmin,
  output logic             o_run_start,
  output logic             o_dir_reverse,
  output logic             o_lost_motion,
  output logic             o_ref_done,
  output logic             o_fuse_start,
  output logic [2:0]       o_fuse_addr,
  output logic [7:0]       o_fuse_data,
  output logic [31:0]      o_param0,
  output logic [31:0]      o_param1
);
  function automatic logic [7:0] byte_at(input logic [63:0] d, input int n);
    byte_at = d[63-8*n -: 8];
  endfunction

  // Byte n of the frame (1-based as printed) lies at byte_at(n-1).
  wire logic [7:0] d1 = byte_at(i_frame_data, 0);
  wire logic [7:0] d2 = byte_at(i_frame_data, 1);
  wire logic [7:0] d3 = byte_at(i_frame_data, 2);
  wire logic [7:0] d4 = byte_at(i_frame_data, 3);
  wire logic [7:0] d5 = byte_at(i_frame_data, 4);
  wire logic [7:0] d6 = byte_at(i_frame_data, 5);
  wire logic [7:0] d7 = byte_at(i_frame_data, 6);
  wire logic [7:0] d8 = byte_at(i_frame_data, 7);

  logic [6:0]  node_addr_q;
  logic        link_watch_en_q;
  lmcd_pkg::lmcd_state_t state_q;
  logic [15:0] second_offset_q;
  logic [3:0]  dual_vmin_q;
  logic [31:0] lost_cnt_q;
  logic [15:0] drops_q;

  wire logic good = i_frame_valid && i_frame_ok; // [RULE18]
  wire logic gp2  = good && (i_frame_id != lmcd_pkg::ID_DIAG)
                    && (i_frame_ptr == lmcd_pkg::PTR_GP2);
  wire logic diag = good && (i_frame_id == lmcd_pkg::ID_DIAG)
                    && (d1 == lmcd_pkg::APP_SEL) && d2[7]; // [RULE19]
  wire logic hit2, hit8;
  lmcd_addr_match u_hit2 (
    .i_addr_byte (d2),
    .i_node_addr (node_addr_q),
    .o_hit       (hit2)
  );
  lmcd_addr_match u_hit8 (
    .i_addr_byte (d3),
    .i_node_addr (node_addr_q),
    .o_hit       (hit8)
  );

  wire logic busy_dual = (state_q == lmcd_pkg::LMCD_DUAL1) ||
                         (state_q == lmcd_pkg::LMCD_DUAL2);
  wire logic run_cmd  = gp2 && d1[7] && (d1[6:0] == lmcd_pkg::CMD_RUN) && hit2; // [RULE1]
  wire logic zero_cmd = gp2 && d1[7] && (d1[6:0] == lmcd_pkg::CMD_ZERO) && hit2;
  wire logic abs_cmd  = good && (i_frame_ptr == lmcd_pkg::PTR_GP4)
                        && (i_frame_id != lmcd_pkg::ID_DIAG) && d1[7]
                        && (d1[6:0] == lmcd_pkg::CMD_ABS) && hit2;
  wire logic dual_cmd  = diag && (d2[6:0] == lmcd_pkg::CMD_DUAL) && hit8;
  wire logic stall_cmd = diag && (d2[6:0] == lmcd_pkg::CMD_STALL) && hit8; // [RULE9]
  wire logic motor_cmd = diag && (d2[6:0] == lmcd_pkg::CMD_MOTOR) && hit8; // [RULE11]
  wire logic fuse_cmd  = diag && (d2[6:0] == lmcd_pkg::CMD_FUSE) && hit8
                         && (d4[7:3] == lmcd_pkg::FUSE_ADDR_MARK)
                         && (d6 == lmcd_pkg::FILL_BYTE) && (d7 == lmcd_pkg::FILL_BYTE)
                         && (d8 == lmcd_pkg::FILL_BYTE); // [RULE15]
  wire logic pos_blocked = busy_dual || i_abs_forbid; // [RULE8] [RULE16]
  wire logic take_run  = run_cmd && !busy_dual;
  wire logic take_abs  = abs_cmd && !pos_blocked;
  wire logic take_dual = dual_cmd && !busy_dual;
  // A frame arriving in the very cycle of the timeout proves the link alive.
  wire logic lost_enter = (state_q == lmcd_pkg::LMCD_RUN) && link_watch_en_q && !i_frame_valid
                          && (lost_cnt_q >= lmcd_pkg::LOST_CYCLES); // [RULE3]
  wire logic any_known = run_cmd || zero_cmd || abs_cmd || dual_cmd || stall_cmd
                         || motor_cmd || fuse_cmd;
  wire logic dropped = i_frame_valid && !any_known;

  // Stall layout: currents, velocities, samples/dir/accel, thresholds, flags.
  wire logic [31:0] stall_word = {d4, d5, d6, d7}; // [RULE10]
  wire logic [7:0]  stall_flags = d8; // [RULE10]
  // Motor layout keeps bits 7, 5 and 1 of byte 8 at one.
  wire logic [7:0]  motor_flags = d8 | 8'hA2; // [RULE12]
  wire logic [10:0] safe_position = {d6[7:5], d7}; // [RULE12]

  logic [31:0] param0_q;
  logic [31:0] param1_q;
  logic        ref_done_q;
  logic        start_q, rel_q, run_q, fuse_q, lost_q;
  logic [15:0] tgt_q;
  logic [3:0]  vmax_q, vmin_q;
  logic [2:0]  faddr_q;
  logic [7:0]  fdata_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      param0_q <= 32'h0000_0000;
      param1_q <= 32'h0000_0000;
    end else if (stall_cmd) begin
      param0_q <= stall_word;
      param1_q <= {param1_q[31:8], stall_flags};
    end else if (motor_cmd) begin
      // Applied at once even mid-motion; the position controller reads it live.
      // Sample count and thresholds belong to the stall command and are kept.
      param0_q <= {d4, d5, param0_q[15:13], d6[4:0], param0_q[7:0]}; // [RULE12] [RULE13]
      param1_q <= {param1_q[31:19], safe_position, motor_flags}; // [RULE13]
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    start_q <= 1'b0;
    run_q   <= 1'b0;
    fuse_q  <= 1'b0;
    if (I_RESET) begin
      state_q         <= lmcd_pkg::LMCD_IDLE;
      rel_q           <= 1'b0;
      tgt_q           <= 16'h0000;
      vmax_q          <= 4'h0;
      vmin_q          <= 4'h0;
      second_offset_q <= 16'h0000;
      dual_vmin_q     <= 4'h0;
      ref_done_q      <= 1'b0;
      faddr_q         <= 3'h0;
      fdata_q         <= 8'h00;
    end else begin
      if (fuse_cmd) begin
        fuse_q  <= 1'b1; // [RULE15]
        faddr_q <= d4[2:0];
        fdata_q <= d5;
      end
      if (zero_cmd) begin
        ref_done_q <= 1'b1; // [RULE17]
      end
      case (state_q)
        lmcd_pkg::LMCD_DUAL1: begin
          if (i_move_done) begin
            start_q <= 1'b1;
            rel_q   <= 1'b1;
            tgt_q   <= second_offset_q;
            vmax_q  <= dual_vmin_q;
            vmin_q  <= dual_vmin_q; // [RULE6]
            state_q <= lmcd_pkg::LMCD_DUAL2;
          end
        end
        lmcd_pkg::LMCD_DUAL2: begin
          if (i_move_done) begin
            ref_done_q <= 1'b1; // [RULE7]
            state_q    <= lmcd_pkg::LMCD_IDLE;
          end
        end
        default: begin
          if (take_dual) begin
            start_q         <= 1'b1;
            rel_q           <= 1'b0;
            tgt_q           <= {d5, d6}; // [RULE5]
            vmax_q          <= d4[7:4];
            vmin_q          <= d4[3:0];
            second_offset_q <= {d7, d8};
            dual_vmin_q     <= d4[3:0];
            state_q         <= lmcd_pkg::LMCD_DUAL1; // [RULE6]
          end else if (take_abs) begin
            start_q <= 1'b1;
            rel_q   <= 1'b0;
            tgt_q   <= {d3, d4};
            vmax_q  <= param0_q[23:20];
            vmin_q  <= param0_q[19:16];
            state_q <= lmcd_pkg::LMCD_ABS; // [RULE16]
          end else if (take_run) begin
            run_q   <= 1'b1;
            state_q <= lmcd_pkg::LMCD_RUN;
          end else if (lost_enter) begin
            state_q <= lmcd_pkg::LMCD_LOST; // [RULE3]
          end else if ((state_q == lmcd_pkg::LMCD_ABS || state_q == lmcd_pkg::LMCD_LOST)
                       && i_move_done) begin
            state_q <= lmcd_pkg::LMCD_IDLE;
          end
        end
      endcase
    end
  end

  // Silence counter; any received frame restarts it.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET || i_frame_valid || state_q != lmcd_pkg::LMCD_RUN) begin
      lost_cnt_q <= 32'h0000_0000;
    end else if (lost_cnt_q < lmcd_pkg::LOST_CYCLES) begin
      lost_cnt_q <= lost_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= lost_enter; // [RULE3]
    end
  end

  // Registers: Avalon slave, zero-wait writes and one wait state on reads; reads return data one cycle after capture.
  logic [31:0] rdata_q;
  logic        rd_pend_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      node_addr_q     <= lmcd_pkg::NODE_ADDR_RST;
      link_watch_en_q <= 1'b1;
      drops_q         <= 16'h0000;
      rdata_q         <= 32'h0000_0000;
      rd_pend_q       <= 1'b0;
    end else begin
      rd_pend_q <= i_avs_read && !rd_pend_q;
      if (dropped) begin
        drops_q <= drops_q + 16'h0001; // [RULE19]
      end
      if (i_avs_write && i_avs_address == lmcd_pkg::REG_CTRL) begin
        node_addr_q     <= i_avs_writedata[6:0];
        link_watch_en_q <= i_avs_writedata[8];
      end
      if (i_avs_read) begin
        case (i_avs_address)
          lmcd_pkg::REG_CTRL:   rdata_q <= {23'h0, link_watch_en_q, 1'b0, node_addr_q};
          lmcd_pkg::REG_STATUS: rdata_q <= {27'h0, ref_done_q, 1'b0, state_q};
          lmcd_pkg::REG_PARAM0: rdata_q <= param0_q;
          lmcd_pkg::REG_PARAM1: rdata_q <= param1_q;
          lmcd_pkg::REG_TARGET: rdata_q <= {rel_q, 11'h0, vmax_q, tgt_q};
          lmcd_pkg::REG_FUSE:   rdata_q <= {21'h0, faddr_q, fdata_q};
          lmcd_pkg::REG_DROPS:  rdata_q <= {16'h0, drops_q};
          default:              rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_avs_waitrequest = i_avs_read && !rd_pend_q;
  assign o_avs_readdata    = rdata_q;
  assign o_move_start      = start_q;
  assign o_move_target     = tgt_q;
  assign o_move_relative   = rel_q;
  assign o_move_vmax       = vmax_q;
  assign o_move_vmin       = vmin_q;
  assign o_run_start       = run_q;
  // Direction polarity is masked while running continuously.
  assign o_dir_reverse     = (state_q == lmcd_pkg::LMCD_RUN) ? 1'b0 : param0_q[12]; // [RULE2]
  assign o_lost_motion     = lost_q;
  assign o_ref_done        = ref_done_q;
  assign o_fuse_start      = fuse_q;
  assign o_fuse_addr       = faddr_q;
  assign o_fuse_data       = fdata_q;
  assign o_param0          = param0_q;
  assign o_param1          = param1_q;

  a_dual_second_move: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE6]
    state_q == lmcd_pkg::LMCD_DUAL1 && i_move_done |=> o_move_start && o_move_relative
      && o_move_vmax == $past(dual_vmin_q))
    else $error("second dual move wrong");
  a_dual_ref_done: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE7]
    state_q == lmcd_pkg::LMCD_DUAL2 && i_move_done |=> o_ref_done)
    else $error("reference flag not set after dual");
  a_dual_no_preempt: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE8]
    state_q == lmcd_pkg::LMCD_DUAL1 && !i_move_done |=> state_q == lmcd_pkg::LMCD_DUAL1)
    else $error("dual sequence interrupted");
  a_run_dir_mask: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE2]
    state_q == lmcd_pkg::LMCD_RUN |-> !o_dir_reverse)
    else $error("direction used in run");
  a_run_accept: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE1]
    run_cmd && !busy_dual |=> o_run_start)
    else $error("run command not taken");
  a_bad_frame: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE18]
    i_frame_valid && !i_frame_ok |=> $stable(param0_q) && !o_move_start)
    else $error("bad frame acted on");
  a_fuse_start: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE15]
    fuse_cmd |=> o_fuse_start && o_fuse_addr == $past(d4[2:0]))
    else $error("fuse not started");
  a_abs_forbid: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE16]
    abs_cmd && i_abs_forbid && !busy_dual |=> !o_move_start)
    else $error("forbidden absolute move started");
  a_motor_live: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE13]
    motor_cmd |=> o_param1[7:0] == ($past(d8) | 8'hA2))
    else $error("motor flags not applied");
  a_zero_ref: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE17]
    zero_cmd |=> o_ref_done)
    else $error("zero command left flag clear");
  a_lost_once: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET) // [RULE3]
    o_lost_motion |-> state_q == lmcd_pkg::LMCD_LOST ##1 !o_lost_motion)
    else $error("lost-link pulse not single");
endmodule
`default_nettype wire

/* File: tb/lmcd_frame_master.sv */
`default_nettype none
module lmcd_frame_master (
  input  wire logic        i_clk,
  output logic             o_valid,
  output logic             o_ok,
  output logic [5:0]       o_id,
  output logic [3:0]       o_ptr,
  output logic [63:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_ok    = 1'b0;
    o_id    = 6'h00;
    o_ptr   = 4'h0;
    o_data  = 64'h0;
  end
  // Each frame reaches the decoder whole, in one pulse, fill bytes included.
  task automatic send(input logic [5:0] id, input logic [3:0] ptr, input logic [63:0] data,
                      input logic ok);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_ok    <= ok;
    o_id    <= id;
    o_ptr   <= ptr;
    o_data  <= data;
    @(posedge i_clk);
    // Stale fields are inverted so that a missed pulse cannot reuse them.
    o_valid <= 1'b0;
    o_ok    <= ~ok;
    o_id    <= ~id;
    o_ptr   <= ~ptr;
    o_data  <= ~data;
  endtask
endmodule
`default_nettype wire

/* File: tb/lin_motion_command_decoder_tb.sv */
`default_nettype none
module lin_motion_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [5:0]  id;
    logic [3:0]  ptr;
    logic [63:0] data;
    logic        ok;
    logic        forbid;
    logic [2:0]  pulses;
  } lmcd_row_t;
  logic        clk, rst, move_done, abs_forbid, avs_read, avs_write;
  logic [7:0]  avs_address;
  logic [31:0] avs_wdata, q, q0;
  logic        f_valid, f_ok;
  logic [5:0]  f_id;
  logic [3:0]  f_ptr;
  logic [63:0] f_data;
  logic [31:0] o_avs_readdata, o_param0, o_param1;
  logic        o_avs_waitrequest, o_move_start, o_move_relative, o_run_start;
  logic        o_dir_reverse, o_lost_motion, o_ref_done, o_fuse_start;
  logic [15:0] o_move_target;
  logic [3:0]  o_move_vmax, o_move_vmin;
  logic [2:0]  o_fuse_addr;
  logic [7:0]  o_fuse_data;
  int          num_errors = 0;
  int          compares = 0;
  int          n;
  lmcd_row_t   rows [8] = '{
    '{6'h3C, 4'h0, 64'h809000FB5AFFFFFF, 1'b1, 1'b0, 3'b001},
    '{6'h11, 4'h1, 64'h8B00432100000000, 1'b1, 1'b1, 3'b000},
    '{6'h11, 4'h1, 64'h8B00123400000000, 1'b1, 1'b0, 3'b010},
    '{6'h3C, 4'h0, 64'h818800A312340040, 1'b1, 1'b0, 3'b000},
    '{6'h01, 4'h0, 64'h9700000000000000, 1'b0, 1'b0, 3'b000},
    '{6'h01, 4'h0, 64'h9785000000000000, 1'b1, 1'b0, 3'b000},
    '{6'h01, 4'h0, 64'h9780000000000000, 1'b1, 1'b0, 3'b100},
    '{6'h01, 4'h0, 64'h9733000000000000, 1'b1, 1'b0, 3'b100}
  };
  lmcd_frame_master i_lmcd_frame_master (.i_clk(clk), .o_valid(f_valid), .o_ok(f_ok),
    .o_id(f_id), .o_ptr(f_ptr), .o_data(f_data));
  lmcd_top i_lmcd_top (.I_CORE_CLK(clk), .I_RESET(rst), .i_frame_valid(f_valid),
    .i_frame_ok(f_ok), .i_frame_id(f_id), .i_frame_ptr(f_ptr), .i_frame_data(f_data),
    .i_move_done(move_done), .i_abs_forbid(abs_forbid), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_move_start(o_move_start), .o_move_target(o_move_target),
    .o_move_relative(o_move_relative), .o_move_vmax(o_move_vmax), .o_move_vmin(o_move_vmin),
    .o_run_start(o_run_start), .o_dir_reverse(o_dir_reverse), .o_lost_motion(o_lost_motion),
    .o_ref_done(o_ref_done), .o_fuse_start(o_fuse_start), .o_fuse_addr(o_fuse_addr),
    .o_fuse_data(o_fuse_data), .o_param0(o_param0), .o_param1(o_param1));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  // Waitrequest and read data are both taken at the rising edge that ends the wait.
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write   <= w;
    avs_read    <= ~w;
    avs_wdata   <= d;
    @(posedge clk);
    while (o_avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk("bus wait", 32'h0, 32'(k == 50));
    q = o_avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic done_pulse();
    @(posedge clk);
    move_done <= 1'b1;
    @(posedge clk);
    move_done <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    move_done = 1'b0;
    abs_forbid = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_wdata = 32'h0;
    do_reset();
    avs(1'b0, lmcd_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h00000100, q);
    avs(1'b0, 8'hFC, 32'h0);
    chk("unmapped read", 32'h0, q);
    i_lmcd_frame_master.send(6'h01, 4'h0, 64'h8600000000000000, 1'b1);
    #1;
    chk("ref done zero", 32'h1, 32'(o_ref_done));
    i_lmcd_frame_master.send(6'h3C, 4'h0, 64'h8096005CA7F93E6B, 1'b1);
    #1;
    chk("dir stall", 32'h1, 32'(o_dir_reverse));
    chk("stall word", 32'h5CA7F93E, o_param0);
    chk("stall flags", 32'h0000006B, o_param1);
    foreach (rows[i]) begin
      @(posedge clk);
      abs_forbid <= rows[i].forbid;
      i_lmcd_frame_master.send(rows[i].id, rows[i].ptr, rows[i].data, rows[i].ok);
      #1;
      chk("pulses", 32'(rows[i].pulses), 32'({o_run_start, o_move_start, o_fuse_start}));
    end
    chk("dir run", 32'h0, 32'(o_dir_reverse));
    chk("fuse field", 32'h35A, 32'({o_fuse_addr, o_fuse_data}));
    chk("abs target", 32'h1234, 32'(o_move_target));
    chk("abs speed", 32'hA7, 32'({o_move_vmax, o_move_vmin}));
    n = 0;
    while (o_lost_motion !== 1'b1 && n < 10100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("lost delay", 32'h1, 32'(n > lmcd_pkg::LOST_CYCLES - 20 && n < lmcd_pkg::LOST_CYCLES + 20));
    do_reset();
    #1;
    chk("ref done reset", 32'h0, 32'(o_ref_done));
    avs(1'b1, lmcd_pkg::REG_CTRL, 32'h00000105);
    avs(1'b0, lmcd_pkg::REG_CTRL, 32'h0);
    chk("ctrl write", 32'h00000105, q);
    i_lmcd_frame_master.send(6'h3C, 4'h0, 64'h808985C4A3F55B00, 1'b1);
    #1;
    chk("motor word", 32'hC4A31500, o_param0);
    chk("safe pos", 32'h75B, 32'(o_param1[18:8]));
    chk("fixed bits", 32'hA2, 32'(o_param1[7:0]));
    i_lmcd_frame_master.send(6'h3C, 4'h0, 64'h808885A312340040, 1'b1);
    #1;
    chk("dual first", 32'h011234A3, {7'h0, o_move_start, o_move_target, o_move_vmax, o_move_vmin});
    chk("dual rel1", 32'h0, 32'(o_move_relative));
    i_lmcd_frame_master.send(6'h11, 4'h1, 64'h8B00555500000000, 1'b1);
    #1;
    chk("dual busy", 32'h0, 32'(o_move_start));
    done_pulse();
    chk("dual second", 32'h00104033, {11'h0, o_move_relative, o_move_target[11:0], o_move_vmax, o_move_vmin});
    chk("dual start2", 32'h1, 32'(o_move_start));
    done_pulse();
    chk("ref done dual", 32'h1, 32'(o_ref_done));
    avs(1'b0, lmcd_pkg::REG_STATUS, 32'h0);
    chk("status ref", 32'h1, 32'(q[4]));
    avs(1'b0, lmcd_pkg::REG_DROPS, 32'h0);
    q0 = q;
    i_lmcd_frame_master.send(6'h3C, 4'h0, 64'h80FF000000000000, 1'b1);
    avs(1'b0, lmcd_pkg::REG_DROPS, 32'h0);
    chk("drops", q0 + 32'h1, q);
    complete_run();
  end
endmodule
`default_nettype wire
